/* inc/gcp_pkg.sv */
package gcp_pkg;
  localparam int unsigned GCP_PINS = 32;
  localparam logic [7:0] OP_PREFETCH = 8'h01;
  localparam logic [7:0] OP_ACTIVATE = 8'h02;
  localparam logic [7:0] OP_CFG_WR   = 8'h23;
  localparam logic [7:0] OP_CFG_RD   = 8'h24;
  localparam logic [7:0] OP_OUT_WR   = 8'h25;
  localparam logic [7:0] OP_OUT_RD   = 8'h26;
  localparam logic [7:0] OP_RSV_RD   = 8'h27;
  localparam logic [1:0] CFG_KEEP    = 2'h0;
  localparam logic [1:0] CFG_INPUT   = 2'h1;
  localparam logic [1:0] CFG_PUSH    = 2'h2;
  localparam logic [1:0] CFG_OPEN    = 2'h3;
  localparam logic [3:0] WR_BYTES    = 4'h9;
  localparam logic [3:0] PRE_BYTES   = 4'h2;
  localparam logic [3:0] CNT_SAT     = 4'hA;
  localparam logic [2:0] FLASH_LAST  = 3'h7;
  localparam logic [4:0] REG_CMD     = 5'h00;
  localparam logic [4:0] REG_WDATA0  = 5'h04;
  localparam logic [4:0] REG_WDATA1  = 5'h08;
  localparam logic [4:0] REG_RDATA0  = 5'h0C;
  localparam logic [4:0] REG_RDATA1  = 5'h10;
  localparam logic [4:0] REG_STATUS  = 5'h14;
  localparam logic [4:0] REG_IRQ_ST  = 5'h18;
  localparam logic [4:0] REG_IRQ_MSK = 5'h1C;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_ERR    = 1;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;

  // Bytes returned by an activate for a prefetched opcode, zero if none
  function automatic logic [3:0] gcp_rsp_len(input logic [7:0] op);
    if (op == OP_CFG_RD) begin
      return 4'h8;
    end else if (op == OP_OUT_RD || op == OP_RSV_RD) begin
      return 4'h4;
    end else begin
      return 4'h0;
    end
  endfunction : gcp_rsp_len
endpackage : gcp_pkg

/* inc/gcp_link_if.sv */
interface gcp_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_last;
  logic       h2d_ready;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_last;
  logic       dev_err;
  modport dev (input h2d_valid, h2d_data, h2d_last,
               output h2d_ready, d2h_valid, d2h_data, d2h_last, dev_err);
  modport hst (output h2d_valid, h2d_data, h2d_last,
               input h2d_ready, d2h_valid, d2h_data, d2h_last, dev_err);
endinterface : gcp_link_if

/* hdl/gcp_flash_loader.sv */
module gcp_flash_loader (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  output logic             flash_rd,
  output logic [2:0]       flash_addr,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_ack,
  output logic [63:0]      ld_cfg,
  output logic             ld_done
);
  import gcp_pkg::*;
  logic [2:0]  addr_reg, addr_next;
  logic [63:0] cfg_reg, cfg_next;
  logic        done_reg, done_next;

  always_comb begin
    addr_next = addr_reg;
    cfg_next  = cfg_reg;
    done_next = done_reg;
    if (!done_reg && flash_ack) begin
      cfg_next[{addr_reg, 3'b000} +: 8] = flash_rdata;
      addr_next = addr_reg + 3'h1;
      if (addr_reg == FLASH_LAST) begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 3'h0;
      cfg_reg  <= 64'h0000_0000_0000_0000;
      done_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      cfg_reg  <= cfg_next;
      done_reg <= done_next;
    end
  end

  assign flash_rd   = !done_reg;
  assign flash_addr = addr_reg;
  assign ld_cfg     = cfg_reg;
  assign ld_done    = done_reg;
endmodule : gcp_flash_loader

/* hdl/gcp_device.sv */
// The implementer's own choices: register access over AHB-Lite and the address map.
module gcp_device (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  gcp_link_if.dev          link,
  input  wire logic [31:0] gpio_in,
  output logic [31:0]      gpio_out,
  output logic [31:0]      gpio_oe,
  output logic             flash_rd,
  output logic [2:0]       flash_addr,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_ack,
  output logic             cfg_loaded,
  output logic             cmd_error
);
  import gcp_pkg::*;
  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_RX, ST_EXEC, ST_TX
  } gcp_dstate_type;

  gcp_dstate_type state_reg, state_next;
  logic [7:0]  op_reg, op_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [63:0] par_reg, par_next;
  logic [63:0] cfg_reg, cfg_next;
  logic [31:0] outv_reg, outv_next;
  logic [7:0]  pend_reg, pend_next;
  logic [63:0] tx_reg, tx_next;
  logic [3:0]  len_reg, len_next;
  logic        err_reg, err_next;
  logic [31:0] pout_reg, pout_next;
  logic [31:0] poe_reg, poe_next;
  logic [63:0] ld_cfg;
  logic        ld_done;
  logic [31:0] rsv;
  logic [31:0] cfg_nz;
  logic        take;

  gcp_flash_loader u_loader (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .flash_rd    (flash_rd),
    .flash_addr  (flash_addr),
    .flash_rdata (flash_rdata),
    .flash_ack   (flash_ack),
    .ld_cfg      (ld_cfg),
    .ld_done     (ld_done)
  );

  // Reserved pins of the held config and nonzero fields of the received config
  always_comb begin
    for (int i = 0; i < GCP_PINS; i++) begin
      rsv[i]    = cfg_reg[2*i +: 2] == CFG_KEEP;
      cfg_nz[i] = par_reg[2*i +: 2] != CFG_KEEP;
    end
  end

  assign link.h2d_ready = state_reg == ST_IDLE || state_reg == ST_RX;
  assign take = link.h2d_valid && link.h2d_ready;

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    cnt_next   = cnt_reg;
    par_next   = par_reg;
    cfg_next   = cfg_reg;
    outv_next  = outv_reg;
    pend_next  = pend_reg;
    tx_next    = tx_reg;
    len_next   = len_reg;
    err_next   = err_reg;
    case (state_reg)
      ST_LOAD: begin
        if (ld_done) begin
          cfg_next   = ld_cfg;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          op_next    = link.h2d_data;
          cnt_next   = 4'h1;
          par_next   = 64'h0000_0000_0000_0000;
          err_next   = 1'b0;
          state_next = link.h2d_last ? ST_EXEC : ST_RX;
        end
      end
      ST_RX: begin
        if (take) begin
          par_next = {link.h2d_data, par_reg[63:8]};
          if (cnt_reg != CNT_SAT) begin
            cnt_next = cnt_reg + 4'h1;
          end
          if (link.h2d_last) begin
            state_next = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
        case (op_reg)
          OP_CFG_WR: begin
            if (cnt_reg != WR_BYTES || (cfg_nz & rsv) != 32'h0000_0000) begin
              err_next = 1'b1;
            end else begin
              for (int i = 0; i < GCP_PINS; i++) begin
                if (par_reg[2*i +: 2] != CFG_KEEP) begin
                  cfg_next[2*i +: 2] = par_reg[2*i +: 2];
                end
              end
            end
          end
          OP_OUT_WR: begin
            if (cnt_reg != WR_BYTES || (par_reg[31:0] & rsv) != 32'h0000_0000)
            begin
              err_next = 1'b1;
            end else begin
              outv_next = (outv_reg & ~par_reg[31:0]) |
                          (par_reg[63:32] & par_reg[31:0]);
            end
          end
          OP_PREFETCH: begin
            if (cnt_reg != PRE_BYTES || gcp_rsp_len(par_reg[63:56]) == 4'h0)
            begin
              err_next = 1'b1;
            end else begin
              pend_next = par_reg[63:56];
            end
          end
          OP_ACTIVATE: begin
            len_next = gcp_rsp_len(pend_reg);
            if (cnt_reg != 4'h1 || len_next == 4'h0) begin
              err_next = 1'b1;
            end else begin
              state_next = ST_TX;
              if (pend_reg == OP_CFG_RD) begin
                tx_next = cfg_reg;
              end else if (pend_reg == OP_OUT_RD) begin
                tx_next = {32'h0000_0000, gpio_in};
              end else begin
                tx_next = {32'h0000_0000, rsv};
              end
            end
          end
          default: begin
            err_next = 1'b1;
          end
        endcase
      end
      ST_TX: begin
        tx_next  = {8'h00, tx_reg[63:8]};
        len_next = len_reg - 4'h1;
        if (len_reg == 4'h1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_LOAD;
      op_reg    <= 8'h00;
      cnt_reg   <= 4'h0;
      par_reg   <= 64'h0000_0000_0000_0000;
      cfg_reg   <= 64'h0000_0000_0000_0000;
      outv_reg  <= 32'h0000_0000;
      pend_reg  <= 8'h00;
      tx_reg    <= 64'h0000_0000_0000_0000;
      len_reg   <= 4'h0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      cnt_reg   <= cnt_next;
      par_reg   <= par_next;
      cfg_reg   <= cfg_next;
      outv_reg  <= outv_next;
      pend_reg  <= pend_next;
      tx_reg    <= tx_next;
      len_reg   <= len_next;
      err_reg   <= err_next;
    end
  end

  // Pin drivers from configuration and stored values
  always_comb begin
    for (int i = 0; i < GCP_PINS; i++) begin
      pout_next[i] = (cfg_reg[2*i +: 2] == CFG_PUSH) && outv_reg[i];
      poe_next[i]  = (cfg_reg[2*i +: 2] == CFG_PUSH) ||
                     ((cfg_reg[2*i +: 2] == CFG_OPEN) && !outv_reg[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pout_reg <= 32'h0000_0000;
      poe_reg  <= 32'h0000_0000;
    end else begin
      pout_reg <= pout_next;
      poe_reg  <= poe_next;
    end
  end

  assign gpio_out      = pout_reg;
  assign gpio_oe       = poe_reg;
  assign link.d2h_valid = state_reg == ST_TX;
  assign link.d2h_data  = tx_reg[7:0];
  assign link.d2h_last  = state_reg == ST_TX && len_reg == 4'h1;
  assign link.dev_err   = err_reg;
  assign cmd_error      = err_reg;
  assign cfg_loaded     = state_reg != ST_LOAD;
endmodule : gcp_device

/* hdl/gcp_host.sv */
module gcp_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  gcp_link_if.hst          link
);
  import gcp_pkg::*;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV, H_WAIT} gcp_hstate_type;

  gcp_hstate_type st_reg, st_next;
  logic [4:0]  ad_reg, ad_next;
  logic        wr_reg, wr_next;
  logic [7:0]  op_reg, op_next;
  logic [31:0] wd0_reg, wd0_next, wd1_reg, wd1_next;
  logic [63:0] rd_reg, rd_next;
  logic [71:0] tx_reg, tx_next;
  logic [3:0]  n_reg, n_next;
  logic [2:0]  rc_reg, rc_next;
  logic        pre_reg, pre_next, act_reg, act_next, err_reg, err_next;
  logic [1:0]  ist_reg, ist_next, msk_reg, msk_next;
  logic        wdp;
  logic        done_ev, err_ev;

  assign wdp = wr_reg && hsize == hsize;

  always_comb begin
    st_next = st_reg;
    ad_next = ad_reg;
    wr_next = 1'b0;
    op_next = op_reg;
    wd0_next = wd0_reg;
    wd1_next = wd1_reg;
    rd_next = rd_reg;
    tx_next = tx_reg;
    n_next = n_reg;
    rc_next = rc_reg;
    pre_next = pre_reg;
    act_next = act_reg;
    err_next = err_reg;
    msk_next = msk_reg;
    done_ev = 1'b0;
    err_ev = 1'b0;
    if (hsel && hready && htrans == HTRANS_NSEQ) begin
      // Accesses beyond the register window park on an unused offset
      ad_next = (haddr[31:5] == 27'h0) ? haddr[4:0] : 5'h1F;
      wr_next = hwrite;
    end
    if (wdp) begin
      if (ad_reg == REG_WDATA0) begin
        wd0_next = hwdata;
      end else if (ad_reg == REG_WDATA1) begin
        wd1_next = hwdata;
      end else if (ad_reg == REG_IRQ_MSK) begin
        msk_next = hwdata[1:0];
      end
    end
    case (st_reg)
      H_IDLE: begin
        if (wdp && ad_reg == REG_CMD) begin
          op_next = hwdata[7:0];
          st_next = H_SEND;
          rd_next = 64'h0000_0000_0000_0000;
          act_next = 1'b0;
          pre_next = gcp_rsp_len(hwdata[7:0]) != 4'h0;
          if (pre_next) begin
            tx_next = {56'h00_0000_0000_0000, hwdata[7:0], OP_PREFETCH};
            n_next = PRE_BYTES;
          end else begin
            tx_next = {wd1_reg, wd0_reg, hwdata[7:0]};
            n_next = WR_BYTES;
          end
        end
      end
      H_SEND: begin
        if (link.h2d_ready) begin
          tx_next = {8'h00, tx_reg[71:8]};
          n_next = n_reg - 4'h1;
          if (n_reg == 4'h1) begin
            st_next = act_reg ? H_RECV : H_WAIT;
            rc_next = 3'h0;
          end
        end
      end
      H_RECV: begin
        if (link.d2h_valid) begin
          rd_next[{rc_reg, 3'b000} +: 8] = link.d2h_data;
          rc_next = rc_reg + 3'h1;
          if (link.d2h_last) begin
            st_next = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (link.h2d_ready) begin
          if (pre_reg && !link.dev_err) begin
            pre_next = 1'b0;
            act_next = 1'b1;
            tx_next = {64'h0000_0000_0000_0000, OP_ACTIVATE};
            n_next = 4'h1;
            st_next = H_SEND;
          end else begin
            st_next = H_IDLE;
            err_next = link.dev_err;
            done_ev = 1'b1;
            err_ev = link.dev_err;
          end
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
    // Sticky events win over a write-one clear
    ist_next = ist_reg;
    if (wdp && ad_reg == REG_IRQ_ST) begin
      ist_next = ist_reg & ~hwdata[1:0];
    end
    ist_next[IRQ_DONE] = ist_next[IRQ_DONE] | done_ev;
    ist_next[IRQ_ERR] = ist_next[IRQ_ERR] | err_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= H_IDLE;
      ad_reg <= 5'h00;
      wr_reg <= 1'b0;
      op_reg <= 8'h00;
      wd0_reg <= 32'h0000_0000;
      wd1_reg <= 32'h0000_0000;
      rd_reg <= 64'h0000_0000_0000_0000;
      tx_reg <= 72'h00_0000_0000_0000_0000;
      n_reg <= 4'h0;
      rc_reg <= 3'h0;
      pre_reg <= 1'b0;
      act_reg <= 1'b0;
      err_reg <= 1'b0;
      ist_reg <= 2'h0;
      msk_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      ad_reg <= ad_next;
      wr_reg <= wr_next;
      op_reg <= op_next;
      wd0_reg <= wd0_next;
      wd1_reg <= wd1_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      n_reg <= n_next;
      rc_reg <= rc_next;
      pre_reg <= pre_next;
      act_reg <= act_next;
      err_reg <= err_next;
      ist_reg <= ist_next;
      msk_reg <= msk_next;
    end
  end

  always_comb begin
    if (ad_reg == REG_CMD) begin
      hrdata = {24'h00_0000, op_reg};
    end else if (ad_reg == REG_WDATA0) begin
      hrdata = wd0_reg;
    end else if (ad_reg == REG_WDATA1) begin
      hrdata = wd1_reg;
    end else if (ad_reg == REG_RDATA0) begin
      hrdata = rd_reg[31:0];
    end else if (ad_reg == REG_RDATA1) begin
      hrdata = rd_reg[63:32];
    end else if (ad_reg == REG_STATUS) begin
      hrdata = {30'h0, err_reg, st_reg != H_IDLE};
    end else if (ad_reg == REG_IRQ_ST) begin
      hrdata = {30'h0, ist_reg};
    end else if (ad_reg == REG_IRQ_MSK) begin
      hrdata = {30'h0, msk_reg};
    end else begin
      hrdata = 32'h0000_0000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(ist_reg & msk_reg);
  assign link.h2d_valid = st_reg == H_SEND;
  assign link.h2d_data = tx_reg[7:0];
  assign link.h2d_last = st_reg == H_SEND && n_reg == 4'h1;
endmodule : gcp_host

/* verif/gcp_link_chk.sv */
module gcp_link_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_last,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_last,
  input wire logic       dev_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import gcp_pkg::*;
  logic       take;
  logic       act_take;
  logic       first_reg;
  logic       first_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  logic [3:0] rcnt_reg;
  logic [3:0] rcnt_next;
  logic [7:0] op_reg;
  logic [7:0] op_next;
  logic [7:0] pf_reg;
  logic [7:0] pf_next;
  logic       pf_hit;

  assign take     = h2d_valid & h2d_ready;
  assign act_take = take & h2d_last & first_reg & (h2d_data == OP_ACTIVATE);
  assign pf_hit   = take & (idx_reg == 4'h1) & (op_reg == OP_PREFETCH);

  // Track byte position, opcode and prefetched read opcode
  always_comb begin
    first_next = take ? h2d_last : first_reg;
    idx_next   = take ? (h2d_last ? 4'h0 : idx_reg + 4'h1) : idx_reg;
    op_next    = (take && first_reg) ? h2d_data : op_reg;
    pf_next    = pf_hit ? h2d_data : pf_reg;
    rcnt_next  = take ? 4'h0 : (d2h_valid ? rcnt_reg + 4'h1 : rcnt_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_reg <= 1'b1;
      idx_reg   <= 4'h0;
      op_reg    <= 8'h00;
      pf_reg    <= 8'h00;
      rcnt_reg  <= 4'h0;
    end else begin
      first_reg <= first_next;
      idx_reg   <= idx_next;
      op_reg    <= op_next;
      pf_reg    <= pf_next;
      rcnt_reg  <= rcnt_next;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_exec_gap: assert property (take && h2d_last |=> !h2d_ready)
    else $error("device accepted a byte during execute");
  chk_exec_short: assert property (take && h2d_last && !act_take
    |=> !h2d_ready ##1 h2d_ready)
    else $error("device not ready one cycle after execute");
  chk_reply_start: assert property (act_take
    |=> !d2h_valid ##1 (d2h_valid || (dev_err && h2d_ready)))
    else $error("activate gave neither reply nor error");
  chk_reply_src: assert property ($rose(d2h_valid) |-> $past(act_take, 2))
    else $error("reply byte without activate");
  chk_reply_len: assert property (d2h_valid && d2h_last
    |-> rcnt_reg == ((pf_reg == OP_CFG_RD) ? 4'h7 : 4'h3))
    else $error("reply length wrong for prefetched opcode");
  chk_reply_run: assert property (d2h_valid && !d2h_last |=> d2h_valid)
    else $error("reply bytes not contiguous");
  chk_ready_back: assert property (d2h_valid && d2h_last
    |=> h2d_ready && !d2h_valid)
    else $error("device not ready after reply");
  chk_reply_busy: assert property (d2h_valid |-> !h2d_ready)
    else $error("device ready while replying");
  chk_err_clear: assert property (take && first_reg |=> !dev_err)
    else $error("error flag not cleared by new command");
  chk_host_hold: assert property (h2d_valid && !h2d_ready
    |=> h2d_valid && $stable(h2d_data) && $stable(h2d_last))
    else $error("host changed an untaken byte");

  cover property (act_take && pf_reg == OP_CFG_RD);
  cover property (take && first_reg && h2d_data == OP_CFG_WR);
  cover property ($rose(dev_err));
endmodule : gcp_link_chk

/* verif/gpio_command_port_bench.sv */
module gpio_command_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gcp_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [63:0] d;
    logic        err;
  } gcp_row_type;
  localparam logic [63:0] CFG0 = 64'h0055_AAFF_55AA_FF55;
  localparam logic [31:0] RSV  = 32'hF000_0000;
  localparam gcp_row_type ROWS [14] = '{
    '{OP_CFG_RD, 64'h0, 1'b0}, '{OP_RSV_RD, 64'h0, 1'b0},
    '{OP_OUT_WR, 64'h0000_A5A5_0000_FFFF, 1'b0}, '{OP_OUT_RD, 64'h0, 1'b0},
    '{OP_CFG_WR, 64'h0000_0000_E400_00AA, 1'b0}, '{OP_OUT_RD, 64'h0, 1'b0},
    '{OP_CFG_RD, 64'h0, 1'b0},
    '{OP_CFG_WR, 64'h0100_0000_0000_0055, 1'b1}, '{OP_CFG_RD, 64'h0, 1'b0},
    '{OP_OUT_WR, 64'hFFFF_FFFF_8000_0001, 1'b1}, '{OP_OUT_RD, 64'h0, 1'b0},
    '{OP_OUT_WR, 64'h0000_0000_0000_0F0F, 1'b0}, '{OP_OUT_RD, 64'h0, 1'b0},
    '{OP_ACTIVATE, 64'h0, 1'b1}};
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [31:0] gpio_in;
  logic [31:0] gpio_out;
  logic [31:0] gpio_oe;
  logic [31:0] ext_lvl;
  logic        flash_rd;
  logic [2:0]  flash_addr;
  logic [7:0]  flash_rdata;
  logic        flash_ack;
  logic        cfg_loaded;
  logic        cmd_error;
  logic [63:0] cfg_m;
  logic [31:0] val_m;
  logic [31:0] q;
  int          fails;
  int          checks_done;

  gcp_link_if link ();
  gcp_device i_gcp_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .flash_ack(flash_ack), .cfg_loaded(cfg_loaded), .cmd_error(cmd_error));
  gcp_host i_gcp_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
  gcp_link_chk i_gcp_link_chk (.hclk(hclk), .hresetn(hresetn),
    .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data),
    .h2d_last(link.h2d_last), .h2d_ready(link.h2d_ready),
    .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data),
    .d2h_last(link.d2h_last), .dev_err(link.dev_err));

  // Pin level: driven bits follow the device, released bits the board
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Flash answers each request one cycle later with one pulse
  always @(posedge hclk) begin
    if (flash_rd && !flash_ack) begin
      flash_ack   <= 1'b1;
      flash_rdata <= CFG0[{flash_addr, 3'h0} +: 8];
    end else begin
      flash_ack   <= 1'b0;
      flash_rdata <= ~flash_rdata;
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NSEQ;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      fails++;
      wrap_up();
    end
  endtask : ahb

  function automatic logic [31:0] lvl_f();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      case (cfg_m[2*i +: 2])
        CFG_PUSH: r[i] = val_m[i];
        CFG_OPEN: r[i] = val_m[i] & ext_lvl[i];
        default:  r[i] = ext_lvl[i];
      endcase
    end
    return r;
  endfunction : lvl_f

  task automatic do_row(input gcp_row_type r);
    logic [31:0] q0;
    logic [31:0] q1;
    int          n;
    ahb(1'b1, 32'(REG_WDATA0), r.d[31:0], q0);
    ahb(1'b1, 32'(REG_WDATA1), r.d[63:32], q0);
    ahb(1'b1, 32'(REG_CMD), {24'h0, r.op}, q0);
    n = 0;
    do begin ahb(1'b0, 32'(REG_STATUS), 32'h0, q0); n++; end
      while (q0[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      wrap_up();
    end
    chk(64'(q0[1]), 64'(r.err));
    chk(64'(cmd_error), 64'(r.err));
    if (!r.err && r.op == OP_CFG_WR) begin
      for (int i = 0; i < 32; i++) begin
        if (r.d[2*i +: 2] != CFG_KEEP) cfg_m[2*i +: 2] = r.d[2*i +: 2];
      end
    end
    if (!r.err && r.op == OP_OUT_WR) begin
      val_m = (val_m & ~r.d[31:0]) | (r.d[63:32] & r.d[31:0]);
    end
    ahb(1'b0, 32'(REG_RDATA0), 32'h0, q0);
    ahb(1'b0, 32'(REG_RDATA1), 32'h0, q1);
    if (r.op == OP_CFG_RD) chk({q1, q0}, cfg_m);
    if (r.op == OP_OUT_RD) chk(64'(q0), 64'(lvl_f()));
    if (r.op == OP_RSV_RD) chk(64'(q0), 64'(RSV));
  endtask : do_row

  task automatic boot(input int cycles);
    int n;
    hresetn <= 1'b0;
    repeat (cycles) @(posedge hclk);
    hresetn <= 1'b1;
    cfg_m = CFG0;
    val_m = 32'h0;
    n = 0;
    do begin @(posedge hclk); n++; end while (cfg_loaded !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      wrap_up();
    end
    @(posedge hclk);
  endtask : boot

  initial begin
    fails = 0;
    checks_done = 0;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_lvl = 32'h3C96_69C3;
    boot(10);
    foreach (ROWS[i]) begin
      do_row(ROWS[i]);
      $display("row test %0d done", i);
    end
    // Masked and unmasked error interrupt, write-one-clear
    ahb(1'b1, 32'(REG_IRQ_MSK), 32'h0000_0002, q);
    ahb(1'b0, 32'(REG_IRQ_MSK), 32'h0, q);
    chk(64'(q), 64'h2);
    do_row(ROWS[7]);
    chk(64'(irq), 64'h1);
    ahb(1'b1, 32'(REG_IRQ_ST), 32'h0000_0003, q);
    @(posedge hclk);
    chk(64'(irq), 64'h0);
    ahb(1'b1, 32'(REG_IRQ_MSK), 32'h0, q);
    do_row(ROWS[9]);
    chk(64'(irq), 64'h0);
    ahb(1'b0, 32'(REG_IRQ_ST), 32'h0, q);
    chk(64'(q[1:0]), 64'h3);
    $display("interrupt test done");
    ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, q);
    ahb(1'b0, 32'h0000_0040, 32'h0, q);
    chk(64'(q), 64'h0);
    chk(64'(hresp), 64'h0);
    $display("unmapped test done");
    // Mid-run reset with an interrupt pending: pins and irq released
    ahb(1'b1, 32'(REG_IRQ_MSK), 32'h0000_0003, q);
    @(posedge hclk);
    chk(64'(irq), 64'h1);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk(64'(gpio_oe), 64'h0);
    chk(64'(irq), 64'h0);
    // A write sent while defaults load is held until they are in
    @(posedge hclk);
    hresetn <= 1'b1;
    cfg_m = CFG0;
    val_m = 32'h0;
    do_row(ROWS[2]);
    do_row(ROWS[0]);
    do_row(ROWS[3]);
    $display("reset test done");
    wrap_up();
  end
endmodule : gpio_command_port_bench
